/* src/clk_mode_regs.vh */
`ifndef CLK_MODE_REGS_VH
`define CLK_MODE_REGS_VH

// Register addresses on the device's register port
`define OSC_SETTLE_SELECT_ADDR 8'h00
`define OSC_SETTLE_COUNTER_ADDR 8'h01
`define CLOCK_RUN_CONTROL_ADDR 8'h02
`define CLOCK_SYS_CONTROL_ADDR 8'h03
`define PLL_CONTROL_REG_ADDR  8'h04
`define PERIPH_STOP_ADDR      8'h05

// Field positions
`define MAIN_OSC_HALT_BIT     7
`define CPU_SUB_CLOCK_SEL_BIT 6
`define PLL_POWER_ON_BIT      0
`define PLL_OUTPUT_SEL_BIT    2
`define PLL_OUTPUT_OPT_BIT    1
`define PLL_AUX_STATE_BIT     3

// Reset values of the shadow copies
`define CLOCK_RUN_RESET       8'hc0
`define CLOCK_SYS_RESET       8'h40
`define PLL_CONTROL_RESET     8'h00

// Timing
`define PLL_LOCK_TIME_NS      40000
`define CLK_PERIOD_NS         10
`define PLL_LOCK_CYCLES       ((`PLL_LOCK_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// Command codes
`define CMD_TO_HIGH_SPEED     3'h0
`define CMD_PLL_ENTER         3'h1
`define CMD_PLL_EXIT          3'h2
`define CMD_HALT              3'h3
`define CMD_STOP              3'h4

`endif

/* src/step_sequencer.v */
`timescale 1ns/10ps
`include "clk_mode_regs.vh"

// Wait counter: loads a count, pulses done when it runs out
module step_sequencer #(
  parameter WIDTH = 16
) (
  input  wire             clk_i,
  input  wire             rst_i,
  input  wire             load_i,
  input  wire [WIDTH-1:0] count_i,
  output reg              busy_o,
  output reg              done_o
);
  reg [WIDTH-1:0] cnt_reg;

  always @(posedge clk_i) begin
    if (rst_i) begin
      cnt_reg <= {WIDTH{1'b0}};
      busy_o  <= 1'b0;
      done_o  <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (load_i) begin
        cnt_reg <= count_i;
        busy_o  <= 1'b1;
      end else if (busy_o) begin
        if (cnt_reg <= {{(WIDTH-1){1'b0}}, 1'b1}) begin
          busy_o <= 1'b0;
          done_o <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg - {{(WIDTH-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule

/* src/cpu_clock_mode_switcher.v */
`timescale 1ns/10ps
`include "clk_mode_regs.vh"

// Behaviour
// - To high-speed: clear main oscillator halt, then sub-clock select.
// - For X1 crystal, poll settle counter until stabilization reached.
// - For external main clock, never poll the settle counter.
// - Skip the whole sequence when already on high-speed clock.
// - Settle select programmed at least as long as the awaited settle time.
// - PLL entry: power on, wait 40 us, then set output select.
// - PLL exit: clear output select, then aux state, then power on.
// - Stop all PLL-clocked functions before leaving PLL mode.
// - Before STOP, stop peripherals; for X1 program settle select.
// - In PLL mode, run PLL exit sequence before STOP.
module cpu_clock_mode_switcher #(
  parameter LOCK_CYCLES = `PLL_LOCK_CYCLES,
  parameter [7:0] SETTLE_SEL = 8'h07,
  parameter [7:0] SETTLE_MIN = 8'hff
) (
  input  wire       REF_CLK_I,
  input  wire       RST_I,
  input  wire       CMD_VALID_I,
  input  wire [2:0] CMD_I,
  input  wire       EXT_MAIN_CLK_I,
  input  wire       PLL_OPTION_I,
  input  wire [7:0] RDATA_I,
  input  wire       RVALID_I,
  output reg        CMD_READY_O,
  output reg        CMD_DONE_O,
  output reg        WR_O,
  output reg        RD_O,
  output reg  [7:0] ADDR_O,
  output reg  [7:0] WDATA_O,
  output reg        HALT_REQ_O,
  output reg        STOP_REQ_O
);
  localparam S_IDLE   = 4'h0;
  localparam S_SETTLE = 4'h1;
  localparam S_MAIN_OSC_HALT  = 4'h2;
  localparam S_POLL   = 4'h3;
  localparam S_PWAIT  = 4'h4;
  localparam S_CSS    = 4'h5;
  localparam S_PLL_POWER_ON  = 4'h6;
  localparam S_LOCK   = 4'h7;
  localparam S_PLL_OUTPUT_SELECT = 4'h8;
  localparam S_PSTOP  = 4'h9;
  localparam S_XSEL   = 4'ha;
  localparam S_XAUX   = 4'hb;
  localparam S_XOFF   = 4'hc;
  localparam S_INSTR  = 4'hd;
  localparam S_FINISH = 4'he;

  reg [3:0] state_reg;
  reg [2:0] cmd_reg;
  reg [7:0] run_reg;
  reg [7:0] sys_reg;
  reg [7:0] pll_reg;
  reg       ext_reg;
  reg       lock_load;
  wire      lock_busy;
  wire      lock_done;

  step_sequencer #(
    .WIDTH(16)
  ) lock_timer (
    .clk_i  (REF_CLK_I),
    .rst_i  (RST_I),
    .load_i (lock_load),
    .count_i(LOCK_CYCLES[15:0]),
    .busy_o (lock_busy),
    .done_o (lock_done)
  );

  always @(posedge REF_CLK_I) begin
    if (RST_I) begin
      state_reg   <= S_IDLE;
      cmd_reg     <= 3'h0;
      run_reg     <= `CLOCK_RUN_RESET;
      sys_reg     <= `CLOCK_SYS_RESET;
      pll_reg     <= `PLL_CONTROL_RESET;
      ext_reg     <= 1'b0;
      lock_load   <= 1'b0;
      CMD_READY_O <= 1'b0;
      CMD_DONE_O  <= 1'b0;
      WR_O        <= 1'b0;
      RD_O        <= 1'b0;
      ADDR_O      <= 8'h00;
      WDATA_O     <= 8'h00;
      HALT_REQ_O  <= 1'b0;
      STOP_REQ_O  <= 1'b0;
    end else begin
      WR_O       <= 1'b0;
      RD_O       <= 1'b0;
      CMD_DONE_O <= 1'b0;
      HALT_REQ_O <= 1'b0;
      STOP_REQ_O <= 1'b0;
      lock_load  <= 1'b0;
      case (state_reg)
        S_IDLE: begin
          CMD_READY_O <= 1'b1;
          if (CMD_VALID_I && CMD_READY_O) begin
            CMD_READY_O <= 1'b0;
            cmd_reg     <= CMD_I;
            ext_reg     <= EXT_MAIN_CLK_I;
            case (CMD_I)
              `CMD_TO_HIGH_SPEED: begin
                if (!sys_reg[`CPU_SUB_CLOCK_SEL_BIT])
                  state_reg <= S_FINISH;
                else if (EXT_MAIN_CLK_I)
                  state_reg <= S_MAIN_OSC_HALT;
                else
                  state_reg <= S_SETTLE;
              end
              `CMD_PLL_ENTER: begin
                if (pll_reg[`PLL_OUTPUT_SEL_BIT])
                  state_reg <= S_FINISH;
                else
                  state_reg <= S_PLL_POWER_ON;
              end
              `CMD_PLL_EXIT:
                state_reg <= pll_reg[`PLL_OUTPUT_SEL_BIT] ? S_PSTOP : S_FINISH;
              `CMD_HALT:
                state_reg <= S_INSTR;
              `CMD_STOP: begin
                // PLL must be left before STOP
                if (pll_reg[`PLL_OUTPUT_SEL_BIT])
                  state_reg <= S_PSTOP;
                else
                  state_reg <= S_PSTOP;
              end
              default:
                state_reg <= S_FINISH;
            endcase
          end
        end
        S_SETTLE: begin
          WR_O      <= 1'b1;
          ADDR_O    <= `OSC_SETTLE_SELECT_ADDR;
          WDATA_O   <= SETTLE_SEL;
          state_reg <= (cmd_reg == `CMD_STOP) ? S_INSTR : S_MAIN_OSC_HALT;
        end
        S_MAIN_OSC_HALT: begin
          run_reg[`MAIN_OSC_HALT_BIT] <= 1'b0;
          WR_O      <= 1'b1;
          ADDR_O    <= `CLOCK_RUN_CONTROL_ADDR;
          WDATA_O   <= run_reg & ~(8'h01 << `MAIN_OSC_HALT_BIT);
          state_reg <= ext_reg ? S_CSS : S_POLL;
        end
        S_POLL: begin
          RD_O      <= 1'b1;
          ADDR_O    <= `OSC_SETTLE_COUNTER_ADDR;
          state_reg <= S_PWAIT;
        end
        S_PWAIT: begin
          if (RVALID_I)
            state_reg <= (RDATA_I >= SETTLE_MIN) ? S_CSS : S_POLL;
        end
        S_CSS: begin
          sys_reg[`CPU_SUB_CLOCK_SEL_BIT] <= 1'b0;
          WR_O      <= 1'b1;
          ADDR_O    <= `CLOCK_SYS_CONTROL_ADDR;
          WDATA_O   <= sys_reg & ~(8'h01 << `CPU_SUB_CLOCK_SEL_BIT);
          state_reg <= S_FINISH;
        end
        S_PLL_POWER_ON: begin
          pll_reg[`PLL_POWER_ON_BIT]   <= 1'b1;
          pll_reg[`PLL_OUTPUT_OPT_BIT] <= PLL_OPTION_I;
          WR_O      <= 1'b1;
          ADDR_O    <= `PLL_CONTROL_REG_ADDR;
          WDATA_O   <= (pll_reg | (8'h01 << `PLL_POWER_ON_BIT))
                       & ~(8'h01 << `PLL_OUTPUT_OPT_BIT)
                       | ({7'h00, PLL_OPTION_I} << `PLL_OUTPUT_OPT_BIT);
          lock_load <= 1'b1;
          state_reg <= S_LOCK;
        end
        S_LOCK: begin
          if (lock_done && !lock_busy)
            state_reg <= S_PLL_OUTPUT_SELECT;
        end
        S_PLL_OUTPUT_SELECT: begin
          pll_reg[`PLL_OUTPUT_SEL_BIT] <= 1'b1;
          WR_O      <= 1'b1;
          ADDR_O    <= `PLL_CONTROL_REG_ADDR;
          WDATA_O   <= pll_reg | (8'h01 << `PLL_OUTPUT_SEL_BIT);
          state_reg <= S_FINISH;
        end
        S_PSTOP: begin
          // Halts PLL-clocked timers and analog, or STOP-disabled peripherals
          WR_O      <= 1'b1;
          ADDR_O    <= `PERIPH_STOP_ADDR;
          WDATA_O   <= 8'hff;
          if (pll_reg[`PLL_OUTPUT_SEL_BIT])
            state_reg <= S_XSEL;
          else if (cmd_reg == `CMD_STOP && !ext_reg)
            state_reg <= S_SETTLE;
          else
            state_reg <= (cmd_reg == `CMD_STOP) ? S_INSTR : S_FINISH;
        end
        S_XSEL: begin
          pll_reg[`PLL_OUTPUT_SEL_BIT] <= 1'b0;
          WR_O      <= 1'b1;
          ADDR_O    <= `PLL_CONTROL_REG_ADDR;
          WDATA_O   <= pll_reg & ~(8'h01 << `PLL_OUTPUT_SEL_BIT);
          state_reg <= S_XAUX;
        end
        S_XAUX: begin
          pll_reg[`PLL_AUX_STATE_BIT] <= 1'b0;
          WR_O      <= 1'b1;
          ADDR_O    <= `PLL_CONTROL_REG_ADDR;
          WDATA_O   <= pll_reg & ~(8'h01 << `PLL_AUX_STATE_BIT);
          state_reg <= S_XOFF;
        end
        S_XOFF: begin
          pll_reg[`PLL_POWER_ON_BIT] <= 1'b0;
          WR_O      <= 1'b1;
          ADDR_O    <= `PLL_CONTROL_REG_ADDR;
          WDATA_O   <= pll_reg & ~(8'h01 << `PLL_POWER_ON_BIT);
          if (cmd_reg == `CMD_STOP)
            state_reg <= ext_reg ? S_INSTR : S_SETTLE;
          else
            state_reg <= S_FINISH;
        end
        S_INSTR: begin
          HALT_REQ_O <= (cmd_reg == `CMD_HALT);
          STOP_REQ_O <= (cmd_reg == `CMD_STOP);
          state_reg  <= S_FINISH;
        end
        S_FINISH: begin
          CMD_DONE_O <= 1'b1;
          state_reg  <= S_IDLE;
        end
        default:
          state_reg <= S_IDLE;
      endcase
    end
  end
endmodule

/* test/clk_sw_chk.sv */
`timescale 1ns/10ps
module clk_sw_chk #(
  parameter       LOCK_CYCLES = 4000,
  parameter [7:0] SETTLE_MIN  = 8'hff
) (
  input wire       REF_CLK_I,
  input wire       RST_I,
  input wire       CMD_VALID_I,
  input wire [2:0] CMD_I,
  input wire       EXT_MAIN_CLK_I,
  input wire       PLL_OPTION_I,
  input wire [7:0] RDATA_I,
  input wire       RVALID_I,
  input wire       CMD_READY_O,
  input wire       CMD_DONE_O,
  input wire       WR_O,
  input wire       RD_O,
  input wire [7:0] ADDR_O,
  input wire [7:0] WDATA_O,
  input wire       HALT_REQ_O,
  input wire       STOP_REQ_O
);
  reg  [15:0] lock_cnt_reg;
  reg  [7:0]  settle_reg;
  reg         osc_on_reg;
  wire        wr_pll = WR_O && ADDR_O == 8'h04;
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (RST_I);
  sequence s_sel; wr_pll && WDATA_O[2]; endsequence
  sequence s_take; CMD_VALID_I && CMD_READY_O; endsequence
  // Saturates so a long idle never wraps back under the lock figure
  always @(posedge REF_CLK_I) begin
    if (RST_I) begin
      lock_cnt_reg <= 16'h0000;
      settle_reg   <= 8'h00;
      osc_on_reg   <= 1'b0;
    end else begin
      if (wr_pll && WDATA_O[0] && !WDATA_O[2])
        lock_cnt_reg <= 16'h0000;
      else if (lock_cnt_reg != 16'hffff)
        lock_cnt_reg <= lock_cnt_reg + 16'h0001;
      if (RVALID_I)
        settle_reg <= RDATA_I;
      if (WR_O && ADDR_O == 8'h02)
        osc_on_reg <= !WDATA_O[7];
    end
  end
  a_ext_no_poll: assert property (RD_O && ADDR_O == 8'h01
    |-> !EXT_MAIN_CLK_I) else $error("settle counter read on external clock");
  a_settle_gate: assert property (WR_O && ADDR_O == 8'h03 && !WDATA_O[6]
    && !EXT_MAIN_CLK_I |-> settle_reg >= SETTLE_MIN) else $error("unsettled");
  a_osc_first: assert property (WR_O && ADDR_O == 8'h03 && !WDATA_O[6]
    |-> osc_on_reg) else $error("sub clock left before oscillator on");
  a_lock_wait: assert property (s_sel |-> lock_cnt_reg >= LOCK_CYCLES - 1)
    else $error("pll selected before lock time");
  a_pll_off_last: assert property (wr_pll && !WDATA_O[0]
    |-> !WDATA_O[2] && !WDATA_O[3]) else $error("pll off too early");
  a_stop_done: assert property (STOP_REQ_O |=> CMD_DONE_O && !STOP_REQ_O)
    else $error("stop not closed");
  a_take_drop: assert property (s_take |=> !CMD_READY_O)
    else $error("ready held after take");
  a_halt_done: assert property (HALT_REQ_O
    |=> CMD_DONE_O ##1 CMD_READY_O) else $error("halt not closed");
endmodule
bind cpu_clock_mode_switcher clk_sw_chk #(.LOCK_CYCLES(LOCK_CYCLES),
  .SETTLE_MIN(SETTLE_MIN)) i_chk (.*);

/* test/clk_dev_model.sv */
`timescale 1ns/10ps
module clk_dev_model (
  input  wire       clk_i,
  input  wire       rst_i,
  input  wire       wr_i,
  input  wire       rd_i,
  input  wire [7:0] addr_i,
  input  wire [7:0] wdata_i,
  input  wire       halt_i,
  input  wire       stop_i,
  output reg  [7:0] rdata_o,
  output reg        rvalid_o
);
  reg [7:0] regs [0:7];
  reg [7:0] la [0:63];
  reg [7:0] ld [0:63];
  reg [7:0] settle;
  integer   wn, rds, halts, stops;
  always @(posedge clk_i) begin
    rvalid_o <= rd_i && !rst_i;
    if (rst_i) begin
      regs[2] <= 8'hc0;
      settle  <= 8'h00;
      rdata_o <= 8'h00;
      wn      <= 0;
      rds     <= 0;
      halts   <= 0;
      stops   <= 0;
    end else begin
      // Idle data toggles so a stale read is never mistaken for an answer
      rdata_o <= rd_i ? (addr_i == 8'h01 ? settle : regs[addr_i[2:0]]) : ~rdata_o;
      if (!regs[2][7] && settle != 8'hff)
        settle <= settle + 8'h01;
      if (rd_i)
        rds <= rds + 1;
      if (wr_i) begin
        regs[addr_i[2:0]] <= wdata_i;
        la[wn] <= addr_i;
        ld[wn] <= wdata_i;
        wn <= wn + 1;
      end
      if (halt_i)
        halts <= halts + 1;
      // No wake source modelled: stop is only counted, the model keeps running
      if (stop_i)
        stops <= stops + 1;
    end
  end
endmodule

/* test/testbench.sv */
`timescale 1ns/10ps
`include "clk_mode_regs.vh"
module testbench;
  reg        clk = 1'b0;
  reg        rst = 1'b1;
  reg        valid = 1'b0;
  reg  [2:0] cmd = 3'h0;
  reg        ext = 1'b0;
  reg        opt = 1'b0;
  wire       ready, done, wr, rd, rvalid, halt, stop;
  wire [7:0] addr, wdata, rdata;
  integer    mismatches = 0;
  integer    checked = 0;
  integer    b, i;
  always #5 clk = ~clk;
  cpu_clock_mode_switcher #(.LOCK_CYCLES(20)) i_dut (
    .REF_CLK_I(clk), .RST_I(rst), .CMD_VALID_I(valid), .CMD_I(cmd),
    .EXT_MAIN_CLK_I(ext), .PLL_OPTION_I(opt), .RDATA_I(rdata),
    .RVALID_I(rvalid), .CMD_READY_O(ready), .CMD_DONE_O(done), .WR_O(wr),
    .RD_O(rd), .ADDR_O(addr), .WDATA_O(wdata), .HALT_REQ_O(halt),
    .STOP_REQ_O(stop));
  clk_dev_model i_dev (
    .clk_i(clk), .rst_i(rst), .wr_i(wr), .rd_i(rd), .addr_i(addr),
    .wdata_i(wdata), .halt_i(halt), .stop_i(stop), .rdata_o(rdata),
    .rvalid_o(rvalid));
  task end_sim;
    begin
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  task chk_n(input [31:0] got, input [31:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        mismatches = mismatches + 1;
        $display("MISMATCH %0t got %0h want %0h", $time, got, exp);
      end
    end
  endtask
  task chk_w(input integer k, input [7:0] a, input [7:0] m, input [7:0] v);
    begin
      chk_n(i_dev.la[b+k], a);
      chk_n(i_dev.ld[b+k] & m, v);
    end
  endtask
  // Ready is judged between edges, so the take edge sees it settled
  task run(input [2:0] c);
    integer n;
    begin
      b = i_dev.wn;
      for (n = 0; n < 50 && ready !== 1'b1; n = n + 1) @(negedge clk);
      @(posedge clk);
      cmd <= c;
      valid <= 1'b1;
      @(posedge clk);
      valid <= 1'b0;
      for (n = 0; n < 3000 && done !== 1'b1; n = n + 1) @(negedge clk);
      chk_n(done, 1'b1);
    end
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    run(`CMD_TO_HIGH_SPEED);
    chk_w(0, 8'h00, 8'hff, 8'h07);
    chk_w(1, 8'h02, 8'h80, 8'h00);
    chk_w(2, 8'h03, 8'h40, 8'h00);
    chk_n(i_dev.rds > 0, 1);
    run(`CMD_TO_HIGH_SPEED);
    chk_n(i_dev.wn, b);
    @(posedge clk);
    opt <= 1'b1;
    run(`CMD_PLL_ENTER);
    chk_w(0, 8'h04, 8'h07, 8'h03);
    chk_w(1, 8'h04, 8'h04, 8'h04);
    run(`CMD_PLL_EXIT);
    chk_w(0, 8'h05, 8'hff, 8'hff);
    chk_w(1, 8'h04, 8'h04, 8'h00);
    chk_w(2, 8'h04, 8'h08, 8'h00);
    chk_w(3, 8'h04, 8'h01, 8'h00);
    run(`CMD_HALT);
    chk_n(i_dev.halts, 1);
    @(posedge clk);
    opt <= 1'b0;
    run(`CMD_PLL_ENTER);
    chk_w(0, 8'h04, 8'h07, 8'h01);
    run(`CMD_STOP);
    chk_w(0, 8'h05, 8'hff, 8'hff);
    chk_w(3, 8'h04, 8'h01, 8'h00);
    chk_w(4, 8'h00, 8'hff, 8'h07);
    chk_n(i_dev.stops, 1);
    @(posedge clk);
    ext <= 1'b1;
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    run(`CMD_TO_HIGH_SPEED);
    chk_w(0, 8'h02, 8'h80, 8'h00);
    chk_w(1, 8'h03, 8'h40, 8'h00);
    chk_n(i_dev.rds, 0);
    run(`CMD_STOP);
    for (i = b; i < i_dev.wn; i = i + 1)
      chk_n(i_dev.la[i] == 8'h00, 0);
    chk_n(i_dev.stops, 1);
    end_sim;
  end
  // Whole run needs a few hundred cycles; this bound is generous
  initial begin
    #400000;
    mismatches = mismatches + 1;
    end_sim;
  end
endmodule
